// ==== pkg/lsi_defs.vh ====
`ifndef LSI_DEFS_VH
`define LSI_DEFS_VH

// Command encodings on {row strobe, column strobe, write enable}, active low.
`define LSI_CMD_NOP 3'h7
`define LSI_CMD_ACT 3'h3
`define LSI_CMD_RD 3'h5
`define LSI_CMD_WR 3'h4
`define LSI_CMD_PRE 3'h2
`define LSI_CMD_REF 3'h1

// Address bit ten selects all banks during precharge.
`define LSI_ALL_BANKS_BIT 10

// Request kinds at the user port.
`define LSI_REQ_RD 2'h0
`define LSI_REQ_WR 2'h1
`define LSI_REQ_REF 2'h2
`define LSI_REQ_PDN 2'h3

// Clock divider: the memory clock toggles every this many core cycles plus one.
`define LSI_HALF_PERIOD 2'h1

// Cycles of memory clock between activate and column command.
`define LSI_RCD 2'h1

// Memory clocks from read command to data returned.
`define LSI_CAS_LAT 3'h2

// Byte masks with every lane written and with every lane masked.
`define LSI_MASK_NONE 8'h00
`define LSI_MASK_ALL 8'hff

`endif

// ==== src/lsi_rx_capture.v ====
`timescale 1ns/1ps
`include "lsi_defs.vh"

// Captures one 32-bit read half on a receive clock seen as a sampled pin.
// The receive clock is slow next to the core clock, so its rising edge is
// found after a two-stage synchroniser and the data, held stable by the
// memory over the bit time, is taken through its own two stages.
module lsi_rx_capture #(
    parameter WIDTH = 32
) (
    // Core clock and reset.
    input wire clock,
    input wire arst_n,
    // Returned receive clock and data half from the pins.
    input wire rx_clock,
    input wire [WIDTH-1:0] rx_data,
    // Captured word and its one-cycle strobe in the core domain.
    output reg [WIDTH-1:0] word_q,
    output reg word_valid_q
);

    reg clk_s1_q; // First synchroniser stage, read only by the second.
    reg clk_s2_q; // Second synchroniser stage.
    reg clk_s3_q; // Delayed copy for edge detection.
    reg [WIDTH-1:0] dat_s1_q; // First data stage.
    reg [WIDTH-1:0] dat_s2_q; // Second data stage, aligned with clk_s2_q.

    // Synchronise the receive clock and data, then take data on its rise.
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            dat_s1_q <= {WIDTH{1'b0}};
            dat_s2_q <= {WIDTH{1'b0}};
            word_q <= {WIDTH{1'b0}};
            word_valid_q <= 1'b0;
        end else begin
            clk_s1_q <= rx_clock;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            dat_s1_q <= rx_data;
            dat_s2_q <= dat_s1_q;
            word_valid_q <= clk_s2_q & ~clk_s3_q;
            // A rising receive clock marks the word as safe to sample.
            if (clk_s2_q && !clk_s3_q) begin
                word_q <= dat_s2_q;
            end
        end
    end

endmodule // lsi_rx_capture

// ==== src/lsi_sdram_ctrl.v ====
// Function
// - Per-row active-low selects, A and B identical
// - Masks gate reads, byte enables on writes
// - Write mask with its data, same clock
// - Commands on strobes, two copies each
// - Row address present with row strobe
// - Column address present with column strobe
// - Twelve-bit multiplexed row and column address
// - Write enable low for writes and precharges, duplicated
// - 64-bit bidirectional data, driven on writes
// - Low half captured on first receive clock
// - High half captured on second receive clock
// - Precharge all banks before dropping clock enable
// - Two identical transmit clock copies
// - Output clock copies transmit clock
`timescale 1ns/1ps
`include "lsi_defs.vh"

module lsi_sdram_ctrl #(
    parameter ADDR_W = 12,
    parameter DATA_W = 64,
    parameter CAS_LAT = 3'h2
) (
    // Core clock and reset.
    input wire clock,
    input wire arst_n,
    // User request port.
    input wire req_valid,
    input wire [1:0] req_kind,
    input wire req_row_sel,
    input wire [ADDR_W-1:0] req_row,
    input wire [ADDR_W-1:0] req_col,
    input wire [DATA_W-1:0] req_wdata,
    input wire [7:0] req_byte_en,
    output reg req_ready_q,
    // Read return in the core domain.
    output reg [DATA_W-1:0] rd_data_q,
    output reg rd_valid_q,
    // Memory command pins.
    output reg row0_select_a_n_q,
    output reg row0_select_b_n_q,
    output reg row1_select_a_n_q,
    output reg row1_select_b_n_q,
    output reg row_strobe_a_n_q,
    output reg row_strobe_b_n_q,
    output reg col_strobe_a_n_q,
    output reg col_strobe_b_n_q,
    output reg mem_write_a_n_q,
    output reg mem_write_b_n_q,
    output reg [ADDR_W-1:0] mem_addr_q,
    output reg [7:0] data_mask_q,
    output reg clock_enable_q,
    // Memory data bus, split into three signals.
    input wire [DATA_W-1:0] mem_data_in,
    output reg [DATA_W-1:0] mem_data_out_q,
    output reg mem_data_oe_q,
    // Memory clocks out and receive clocks back.
    output reg mem_tx_clock_a_q,
    output reg mem_tx_clock_b_q,
    output reg feedback_clock_out_q,
    input wire rx_clock_low,
    input wire rx_clock_high
);

    // One-hot states.
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_ACT = 7'h02;
    localparam [6:0] S_COL = 7'h04;
    localparam [6:0] S_WAIT = 7'h08;
    localparam [6:0] S_PRE = 7'h10;
    localparam [6:0] S_PDN = 7'h20;
    localparam [6:0] S_REF = 7'h40;

    reg [1:0] div_q; // Core cycles in the current memory clock half.
    reg mclk_q; // Internal memory clock level.
    reg [6:0] state_q;
    reg [1:0] kind_q; // Latched request kind.
    reg sel_q; // Latched row select.
    reg [ADDR_W-1:0] col_q; // Column address held for the column phase.
    reg [DATA_W-1:0] wdata_q;
    reg [7:0] ben_q;
    reg [2:0] wait_q; // Memory clocks left before read data returns.
    reg [1:0] rcd_q; // Memory clocks left before the column command.
    reg lo_seen_q; // Low half of the current read captured.
    reg hi_seen_q; // High half of the current read captured.
    wire [31:0] lo_word;
    wire [31:0] hi_word;
    wire lo_valid;
    wire hi_valid;
    wire tick; // One-cycle enable where a new memory command launches.

    // Commands change when the memory clock is about to fall, so they are
    // stable around its next rising edge with half a period of margin.
    assign tick = mclk_q && (div_q == `LSI_HALF_PERIOD);

    // Capture the two data halves on their own receive clocks.
    lsi_rx_capture #(.WIDTH(32)) u_rx_lo (
        .clock(clock),
        .arst_n(arst_n),
        .rx_clock(rx_clock_low),
        .rx_data(mem_data_in[31:0]),
        .word_q(lo_word),
        .word_valid_q(lo_valid)
    );

    lsi_rx_capture #(.WIDTH(32)) u_rx_hi (
        .clock(clock),
        .arst_n(arst_n),
        .rx_clock(rx_clock_high),
        .rx_data(mem_data_in[63:32]),
        .word_q(hi_word),
        .word_valid_q(hi_valid)
    );

    // Drive one command onto both copies of every strobe and select.
    task drive_cmd;
        input [2:0] cmd;
        input sel_en;
        input row;
        begin
            row_strobe_a_n_q <= cmd[2];
            row_strobe_b_n_q <= cmd[2];
            col_strobe_a_n_q <= cmd[1];
            col_strobe_b_n_q <= cmd[1];
            mem_write_a_n_q <= cmd[0];
            mem_write_b_n_q <= cmd[0];
            row0_select_a_n_q <= ~(sel_en & ~row);
            row0_select_b_n_q <= ~(sel_en & ~row);
            row1_select_a_n_q <= ~(sel_en & row);
            row1_select_b_n_q <= ~(sel_en & row);
        end
    endtask

    // Clock divider: the memory clock and its copies come from flops.
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 2'h0;
            mclk_q <= 1'b0;
            mem_tx_clock_a_q <= 1'b0;
            mem_tx_clock_b_q <= 1'b0;
            feedback_clock_out_q <= 1'b0;
        end else begin
            if (div_q == `LSI_HALF_PERIOD) begin
                div_q <= 2'h0;
                mclk_q <= ~mclk_q;
                mem_tx_clock_a_q <= ~mclk_q;
                mem_tx_clock_b_q <= ~mclk_q;
                feedback_clock_out_q <= ~mclk_q;
            end else begin
                div_q <= div_q + 2'h1;
            end
        end
    end

    // Command sequencer: one command per memory clock.
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= S_IDLE;
            kind_q <= `LSI_REQ_RD;
            sel_q <= 1'b0;
            col_q <= {ADDR_W{1'b0}};
            wdata_q <= {DATA_W{1'b0}};
            ben_q <= `LSI_MASK_NONE;
            wait_q <= 3'h0;
            rcd_q <= 2'h0;
            req_ready_q <= 1'b0;
            // Every select and strobe copy idles high, a deselected no-operation.
            drive_cmd(`LSI_CMD_NOP, 1'b0, 1'b0);
            mem_addr_q <= {ADDR_W{1'b0}};
            data_mask_q <= `LSI_MASK_ALL;
            clock_enable_q <= 1'b1;
            mem_data_out_q <= {DATA_W{1'b0}};
            mem_data_oe_q <= 1'b0;
        end else begin
            // Ready stands in the cycle just before a launch, so a request seen
            // with it is taken at the very edge that puts its command out.
            req_ready_q <= mclk_q && (div_q + 2'h1 == `LSI_HALF_PERIOD)
                && (state_q == S_IDLE);
            if (tick) begin
                // Default every launch to a deselected no-operation.
                drive_cmd(`LSI_CMD_NOP, 1'b0, 1'b0);
                mem_data_oe_q <= 1'b0;
                data_mask_q <= (state_q == S_WAIT) ? `LSI_MASK_NONE : `LSI_MASK_ALL;
                case (state_q)
                    S_IDLE: begin
                        if (req_valid && req_ready_q) begin
                            kind_q <= req_kind;
                            sel_q <= req_row_sel;
                            col_q <= req_col;
                            wdata_q <= req_wdata;
                            ben_q <= req_byte_en;
                            if (req_kind == `LSI_REQ_RD || req_kind == `LSI_REQ_WR) begin
                                drive_cmd(`LSI_CMD_ACT, 1'b1, req_row_sel);
                                mem_addr_q <= req_row;
                                rcd_q <= `LSI_RCD;
                                state_q <= S_ACT;
                            end else if (req_kind == `LSI_REQ_REF) begin
                                drive_cmd(`LSI_CMD_REF, 1'b1, 1'b0);
                                state_q <= S_REF;
                            end else begin
                                // Power-down: close every bank first.
                                drive_cmd(`LSI_CMD_PRE, 1'b1, 1'b0);
                                mem_addr_q <= {ADDR_W{1'b0}};
                                mem_addr_q[`LSI_ALL_BANKS_BIT] <= 1'b1;
                                state_q <= S_PRE;
                            end
                        end
                    end
                    S_ACT: begin
                        // Hold off the column command until row-to-column delay.
                        if (rcd_q != 2'h0) begin
                            rcd_q <= rcd_q - 2'h1;
                        end else if (kind_q == `LSI_REQ_WR) begin
                            drive_cmd(`LSI_CMD_WR, 1'b1, sel_q);
                            mem_addr_q <= col_q;
                            mem_data_out_q <= wdata_q;
                            mem_data_oe_q <= 1'b1;
                            data_mask_q <= ~ben_q;
                            state_q <= S_COL;
                        end else begin
                            drive_cmd(`LSI_CMD_RD, 1'b1, sel_q);
                            mem_addr_q <= col_q;
                            data_mask_q <= `LSI_MASK_NONE;
                            wait_q <= CAS_LAT;
                            state_q <= S_WAIT;
                        end
                    end
                    S_WAIT: begin
                        // Keep the data masks clear while data returns; mem_data_oe_q stays low.
                        if (wait_q != 3'h0) begin
                            wait_q <= wait_q - 3'h1;
                        end else begin
                            state_q <= S_COL;
                        end
                    end
                    S_COL: begin
                        // Close the row so every bank is idle between requests.
                        drive_cmd(`LSI_CMD_PRE, 1'b1, sel_q);
                        mem_addr_q <= {ADDR_W{1'b0}};
                        mem_addr_q[`LSI_ALL_BANKS_BIT] <= 1'b1;
                        state_q <= S_IDLE;
                    end
                    S_PRE: begin
                        clock_enable_q <= 1'b0;
                        state_q <= S_PDN;
                    end
                    S_PDN: begin
                        // Any request wakes the memory; it is then re-presented.
                        if (req_valid) begin
                            clock_enable_q <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end
                    S_REF: begin
                        state_q <= S_IDLE;
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // Pair the two captured halves into one 64-bit word in the core domain.
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lo_seen_q <= 1'b0;
            hi_seen_q <= 1'b0;
            rd_data_q <= {DATA_W{1'b0}};
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= 1'b0;
            if (state_q != S_WAIT || wait_q != 3'h0) begin
                // Earlier edges sample the bus before the memory drives it, so
                // they are dropped. A limitation: the receive phase shift must
                // land the data edge inside the last wait beat.
                lo_seen_q <= 1'b0;
                hi_seen_q <= 1'b0;
            end else begin
                if (lo_valid && !lo_seen_q) begin
                    lo_seen_q <= 1'b1;
                    rd_data_q[DATA_W/2-1:0] <= lo_word;
                end
                if (hi_valid && !hi_seen_q) begin
                    hi_seen_q <= 1'b1;
                    rd_data_q[DATA_W-1:DATA_W/2] <= hi_word;
                end
                // The valid pulse marks the cycle in which the second half lands.
                rd_valid_q <= (lo_seen_q || lo_valid) && (hi_seen_q || hi_valid)
                    && !(lo_seen_q && hi_seen_q);
            end
        end
    end

endmodule // lsi_sdram_ctrl

// ==== verif/lsi_sdram_ctrl_monitor.sv ====
`timescale 1ns/1ps
`include "lsi_defs.vh"

// Pin checks on the core clock; bound to the controller top.
module lsi_sdram_ctrl_monitor #(
    parameter ADDR_W = 12
) (
    // Core clock and reset.
    input wire clock,
    input wire arst_n,
    // Read return.
    input wire rd_valid_q,
    // Command pins.
    input wire row0_select_a_n_q,
    input wire row0_select_b_n_q,
    input wire row1_select_a_n_q,
    input wire row1_select_b_n_q,
    input wire row_strobe_a_n_q,
    input wire row_strobe_b_n_q,
    input wire col_strobe_a_n_q,
    input wire col_strobe_b_n_q,
    input wire mem_write_a_n_q,
    input wire mem_write_b_n_q,
    input wire [ADDR_W-1:0] mem_addr_q,
    input wire [7:0] data_mask_q,
    input wire clock_enable_q,
    input wire mem_data_oe_q,
    // Memory clocks.
    input wire mem_tx_clock_a_q,
    input wire mem_tx_clock_b_q,
    input wire feedback_clock_out_q
);
    default clocking mon_cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // A command only counts while some row is selected.
    wire sel = !(row0_select_a_n_q && row1_select_a_n_q);
    wire [2:0] cmd = {row_strobe_a_n_q, col_strobe_a_n_q, mem_write_a_n_q};
    reg banks_closed_q; // High once every bank is known precharged.

    // Tracks open banks so power-down can be judged.
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            banks_closed_q <= 1'b1;
        end else if (sel && cmd == `LSI_CMD_ACT) begin
            banks_closed_q <= 1'b0;
        end else if (sel && cmd == `LSI_CMD_PRE && mem_addr_q[`LSI_ALL_BANKS_BIT]) begin
            banks_closed_q <= 1'b1;
        end
    end

    a_select_copies:
    assert property (row0_select_a_n_q == row0_select_b_n_q
        && row1_select_a_n_q == row1_select_b_n_q) else $error("select copies differ");
    a_strobe_copies:
    assert property (row_strobe_a_n_q == row_strobe_b_n_q
        && col_strobe_a_n_q == col_strobe_b_n_q) else $error("strobe copies differ");
    a_write_copies:
    assert property (mem_write_a_n_q == mem_write_b_n_q) else $error("write copies differ");
    a_clock_copies:
    assert property (mem_tx_clock_a_q == mem_tx_clock_b_q) else $error("tx copies differ");
    a_feedback_copy:
    assert property (feedback_clock_out_q == mem_tx_clock_a_q) else $error("feedback differs");
    a_read_mask_open:
    assert property (sel && cmd == `LSI_CMD_RD |-> data_mask_q == 8'h00)
        else $error("read with mask set");
    a_write_data_driven:
    assert property (sel && cmd == `LSI_CMD_WR |-> mem_data_oe_q) else $error("write undriven");
    a_row_addr_holds:
    assert property ($fell(row_strobe_a_n_q) |=> $stable(mem_addr_q) [*3])
        else $error("address moved under row strobe");
    a_precharge_first:
    assert property ($fell(clock_enable_q) |-> banks_closed_q) else $error("power-down open bank");
    a_read_returns:
    assert property ($fell(col_strobe_a_n_q) && row_strobe_a_n_q && mem_write_a_n_q
        |-> ##[1:80] rd_valid_q) else $error("read never returned");
endmodule // lsi_sdram_ctrl_monitor

// ==== verif/lsi_mem_model.sv ====
`timescale 1ns/1ps
`include "lsi_defs.vh"

// Behavioural memory array on the far side of the pins.
module lsi_mem_model #(
    parameter CAS_LAT = 2
) (
    // Clocks and command pins.
    input wire tx_clock,
    input wire fb_clock,
    input wire sel_n,
    input wire row1_n,
    input wire [2:0] cmd,
    input wire [11:0] addr,
    input wire [7:0] mask,
    input wire [63:0] bus,
    // Read reply and returned clocks.
    output reg drive,
    output reg [63:0] rdata,
    output wire rx_low,
    output wire rx_high
);
    reg [63:0] mem [0:63]; // Folded address space is plenty for a bench.
    reg [11:0] open_row_q;
    reg [5:0] rd_key;
    integer b;

    // Returned clocks lag the feedback clock into the data eye.
    assign #40 rx_low = fb_clock;
    assign #45 rx_high = fb_clock;

    initial begin
        drive = 1'b0;
        rdata = 64'h0;
    end

    // Commands are decoded on the rising memory clock.
    always @(posedge tx_clock) begin
        if (!sel_n && cmd == `LSI_CMD_ACT) begin
            open_row_q <= addr;
        end
        if (!sel_n && cmd == `LSI_CMD_WR) begin
            for (b = 0; b < 8; b = b + 1) begin
                if (!mask[b]) begin
                    mem[{!row1_n, open_row_q[1:0], addr[2:0]}][b*8 +: 8] <= bus[b*8 +: 8];
                end
            end
        end
        if (!sel_n && cmd == `LSI_CMD_RD && mask == 8'h00) begin
            rd_key = {!row1_n, open_row_q[1:0], addr[2:0]};
            // Data is valid for one clock only, then the bus is let go.
            fork
                begin
                    repeat (CAS_LAT - 1) @(posedge tx_clock);
                    #6 drive = 1'b1;
                    rdata = mem[rd_key];
                    @(posedge tx_clock);
                    #3 drive = 1'b0;
                end
            join_none
        end
    end
endmodule // lsi_mem_model

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`include "lsi_defs.vh"

module tb;
    // Inputs of the controller.
    reg clock = 1'b0;
    reg arst_n = 1'b0;
    reg req_valid = 1'b0;
    reg [1:0] req_kind = 2'h0;
    reg req_row_sel = 1'b0;
    reg [11:0] req_row = 12'h000;
    reg [11:0] req_col = 12'h000;
    reg [63:0] req_wdata = 64'h0;
    reg [7:0] req_byte_en = 8'h00;
    // Outputs and the resolved data bus.
    wire req_ready_q, rd_valid_q, clock_enable_q, mem_data_oe_q, mdl_drive;
    wire row0_select_a_n_q, row0_select_b_n_q, row1_select_a_n_q, row1_select_b_n_q;
    wire row_strobe_a_n_q, row_strobe_b_n_q, col_strobe_a_n_q, col_strobe_b_n_q;
    wire mem_write_a_n_q, mem_write_b_n_q, rx_clock_low, rx_clock_high;
    wire mem_tx_clock_a_q, mem_tx_clock_b_q, feedback_clock_out_q;
    wire [11:0] mem_addr_q;
    wire [7:0] data_mask_q;
    wire [63:0] rd_data_q, mem_data_in, mem_data_out_q, mdl_data;
    integer fails = 0;
    integer cmp_count = 0;

    always #12.5 clock = ~clock;

    lsi_sdram_ctrl lsi_sdram_ctrl_inst (.*);

    lsi_mem_model lsi_mem_model_inst (
        .tx_clock(mem_tx_clock_a_q),
        .fb_clock(feedback_clock_out_q),
        .sel_n(row0_select_a_n_q & row1_select_a_n_q),
        .row1_n(row1_select_a_n_q),
        .cmd({row_strobe_a_n_q, col_strobe_a_n_q, mem_write_a_n_q}),
        .addr(mem_addr_q),
        .mask(data_mask_q),
        .bus(mem_data_in),
        .drive(mdl_drive),
        .rdata(mdl_data),
        .rx_low(rx_clock_low),
        .rx_high(rx_clock_high)
    );

    // The bus has pull-downs, so a released bus reads zero.
    assign mem_data_in = mem_data_oe_q ? mem_data_out_q : (mdl_drive ? mdl_data : 64'h0);

    task give_verdict;
        begin
            if (fails == 0 && cmp_count > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask

    task check(input [63:0] got, input [63:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("ERROR %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Waits of every kind end here when their bound runs out.
    task timeout;
        begin
            fails = fails + 1;
            give_verdict;
        end
    endtask

    // Holds the request until a ready pulse takes it.
    task issue(input [1:0] kind, input sel, input [11:0] col, input [63:0] wd,
        input [7:0] be);
        integer n;
        begin
            @(negedge clock);
            req_kind = kind;
            req_row_sel = sel;
            req_row = 12'h5a6;
            req_col = col;
            req_wdata = wd;
            req_byte_en = be;
            req_valid = 1'b1;
            for (n = 0; req_ready_q !== 1'b1; n = n + 1) begin
                if (n == 400) timeout;
                @(negedge clock);
            end
            @(negedge clock);
            req_valid = 1'b0;
        end
    endtask

    task read_check(input sel, input [11:0] col, input [63:0] exp);
        integer n;
        begin
            issue(`LSI_REQ_RD, sel, col, 64'h0, 8'h00);
            for (n = 0; rd_valid_q !== 1'b1; n = n + 1) begin
                if (n == 200) timeout;
                @(negedge clock);
            end
            check(rd_data_q, exp);
        end
    endtask

    // Partial and empty byte enables merge into the stored word.
    task t_byte_lanes;
        begin
            issue(`LSI_REQ_WR, 1'b0, 12'h0c5, 64'h1122334455667788, 8'hff);
            read_check(1'b0, 12'h0c5, 64'h1122334455667788);
            issue(`LSI_REQ_WR, 1'b0, 12'h0c5, 64'haabbccddeeff0011, 8'h0f);
            issue(`LSI_REQ_WR, 1'b0, 12'h0c5, 64'hffffffffffffffff, 8'h00);
            read_check(1'b0, 12'h0c5, 64'h11223344eeff0011);
        end
    endtask

    // The second row must not alias the first.
    task t_second_row;
        begin
            issue(`LSI_REQ_WR, 1'b1, 12'h0c5, 64'h0123456789abcdef, 8'hff);
            read_check(1'b1, 12'h0c5, 64'h0123456789abcdef);
            read_check(1'b0, 12'h0c5, 64'h11223344eeff0011);
        end
    endtask

    // Refresh, then power-down, then a read that wakes the memory.
    task t_power_down;
        integer n;
        begin
            issue(`LSI_REQ_REF, 1'b0, 12'h000, 64'h0, 8'h00);
            issue(`LSI_REQ_PDN, 1'b0, 12'h000, 64'h0, 8'h00);
            for (n = 0; clock_enable_q !== 1'b0; n = n + 1) begin
                if (n == 100) timeout;
                @(negedge clock);
            end
            read_check(1'b0, 12'h0c5, 64'h11223344eeff0011);
            check({63'h0, clock_enable_q}, 64'h1);
        end
    endtask

    initial begin
        repeat (20) @(negedge clock);
        // One copy of each command line idles high and the bus is released in reset.
        check({row0_select_a_n_q, row1_select_b_n_q, row_strobe_a_n_q, col_strobe_b_n_q,
            mem_write_a_n_q, data_mask_q, clock_enable_q, mem_data_oe_q,
            mem_tx_clock_a_q, req_ready_q}, {5'h1f, 8'hff, 4'h8});
        arst_n = 1'b1;
        t_byte_lanes;
        t_second_row;
        t_power_down;
        give_verdict;
    end
endmodule // tb

bind lsi_sdram_ctrl lsi_sdram_ctrl_monitor #(.ADDR_W(ADDR_W)) lsi_sdram_ctrl_monitor_inst (.*);
